// [design/can_filter_pkg.sv]
/*
 * package for the receive filter and fifo bookkeeping block: register map,
 * field layout of the filter control word, reset values, carrier structs.
 * assumes one 32-bit axi4-lite slave port and a 100 MHz clock.
 */
package can_filter_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] FILTER_CONTROL_GROUP2_ADDR = 8'h00;
	localparam logic [7:0] FIFO_DIRECTION_ADDR = 8'h04;
	localparam logic [7:0] RX_DROP_COUNT_ADDR = 8'h08;
	localparam logic [7:0] FIFO_USER_ADDRESS_BASE = 8'h40;
	localparam logic [7:0] FIFO_MESSAGE_INDEX_BASE = 8'h80;

	// ----------------------------------------------------------------
	// field layout of one filter byte
	// ----------------------------------------------------------------
	localparam int FILTER_ENABLE_POS = 7;
	localparam int MASK_SELECT_POS = 5;
	localparam int FIFO_SELECT_POS = 0;
	localparam int FIRST_FILTER = 8;
	localparam int NUM_FILTERS = 4;
	localparam int NUM_FIFOS = 16;
	localparam int NUM_MASKS = 4;

	// ----------------------------------------------------------------
	// reset values and sizes
	// ----------------------------------------------------------------
	localparam logic [31:0] FILTER_CONTROL_RESET = 32'h0000_0000;
	localparam logic [15:0] FIFO_DIRECTION_RESET = 16'h0000;
	localparam logic [4:0] MESSAGE_INDEX_RESET = 5'h00;
	localparam logic [31:0] FIFO_AREA_BASE_DEFAULT = 32'h0000_1000;
	localparam logic [31:0] MESSAGE_BYTES = 32'h0000_0010;
	localparam int SLOTS_PER_FIFO = 32;

	// ----------------------------------------------------------------
	// carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic filter_enable;
		logic [1:0] mask_select;
		logic [4:0] fifo_select;
	} filter_field_t;

	typedef struct packed {
		logic [28:0] ident;
	} rx_ident_t;

	typedef struct packed {
		logic [28:0] ident;
		logic [3:0] fifo;
		logic [4:0] slot;
	} store_word_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_RESP = 2'b01
	} bus_state_t;

endpackage

// [design/can_filter_fifo_pointers.sv]
/*
 * receive filters 8 to 11 with their control word, the per-fifo head and
 * tail pointers and their address and index read-backs, over axi4-lite.
 * assumes the mask values, the TX_DONE and RX_TAKEN pulses and a store sink from outside;
 * received identifiers arrive synchronous to CLK with valid and ready.
 */
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - one byte per filter: enable, mask, fifo
// - enable bit makes filter take part
// - mask select picks one of four masks
// - fifo select routes to fifo 0 to 15
// - filter fields writable only while disabled
// - transmit fifo address reads the head
// - receive fifo address reads the tail
// - address bits 1 and 0 read zero
// - transmit index is next message to send
// - receive index is next slot to fill
// - index bits 31 to 5 read zero
module can_filter_fifo_pointers
	import can_filter_pkg::*;
#(
	parameter logic [31:0] FIFO_AREA_BASE = FIFO_AREA_BASE_DEFAULT
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic CLK_EN,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [115:0] MASK_VALUES,
	input wire rx_ident_t RX_IDENT,
	input wire logic RX_VALID,
	output logic RX_READY,
	output store_word_t STORE_DATA,
	output logic STORE_VALID,
	input wire logic STORE_READY,
	input wire logic [15:0] TX_DONE,
	input wire logic [15:0] RX_TAKEN
);

	typedef struct packed {
		logic [31:0] filter_control_group2_r;
		logic [15:0] fifo_transmit_direction_r;
		logic [15:0] drop_count_r;
		logic [NUM_FIFOS*5-1:0] head_r;
		logic [NUM_FIFOS*5-1:0] tail_r;
		store_word_t [1:0] buf_r;
		logic [1:0] buf_count_r;
		logic aw_held_r;
		logic [7:0] aw_addr_r;
		logic w_held_r;
		logic [31:0] w_data_r;
		logic [3:0] w_strb_r;
		bus_state_t wr_state_r;
		logic [1:0] bresp_r;
		bus_state_t rd_state_r;
		logic [31:0] rdata_r;
		logic [1:0] rresp_r;
	} state_t;

	state_t st_r;
	state_t st_nxt;
	logic [NUM_FILTERS-1:0] hit;
	logic [3:0] hit_fifo;
	logic any_hit;
	logic in_take;
	logic out_take;

	// ----------------------------------------------------------------
	// filter compare, one per filter
	// ----------------------------------------------------------------
	for (genvar f = 0; f < NUM_FILTERS; f++) begin : g_filter
		filter_field_t fld;
		logic [28:0] mask;
		logic [28:0] ref_id;
		assign fld = st_r.filter_control_group2_r[f*8 +: 8];
		assign mask = MASK_VALUES[fld.mask_select*29 +: 29];
		// filter reference id held as a constant per filter index
		assign ref_id = 29'(FIRST_FILTER + f);
		assign hit[f] = fld.filter_enable && !fld.fifo_select[4] &&
			(((RX_IDENT.ident ^ ref_id) & mask) == 29'h0);
	end

	// lowest filter number wins when several match
	always_comb begin
		any_hit = 1'b0;
		hit_fifo = 4'h0;
		for (int f = NUM_FILTERS - 1; f >= 0; f--) begin
			if (hit[f]) begin
				any_hit = 1'b1;
				hit_fifo = st_r.filter_control_group2_r[f*8 +: 4];
			end
		end
	end

	// handshakes of the two-entry buffer
	assign RX_READY = CLK_EN && (st_r.buf_count_r != 2'd2);
	assign in_take = RX_VALID && RX_READY;
	assign STORE_VALID = (st_r.buf_count_r != 2'd0);
	assign out_take = CLK_EN && STORE_VALID && STORE_READY;
	assign STORE_DATA = st_r.buf_r[0];

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [7:0] waddr;
		logic [7:0] raddr;
		logic [3:0] n;
		logic [31:0] wbits;
		logic [31:0] mbits;
		logic [4:0] ptr;
		store_word_t entry;
		logic do_store;
		waddr = 8'h00;
		raddr = 8'h00;
		n = 4'h0;
		wbits = 32'h0;
		mbits = 32'h0;
		ptr = 5'h00;
		entry = '0;
		do_store = 1'b0;
		st_nxt = st_r;

		// fifo pointers move on transmit done and on software taking
		for (int q = 0; q < NUM_FIFOS; q++) begin
			if (st_r.fifo_transmit_direction_r[q] && TX_DONE[q])
				st_nxt.tail_r[q*5 +: 5] = st_r.tail_r[q*5 +: 5] + 5'd1;
			if (!st_r.fifo_transmit_direction_r[q] && RX_TAKEN[q])
				st_nxt.tail_r[q*5 +: 5] = st_r.tail_r[q*5 +: 5] + 5'd1;
		end

		// incoming identifier: keep it only when a filter accepts it
		if (in_take && any_hit) begin
			entry.ident = RX_IDENT.ident;
			entry.fifo = hit_fifo;
			entry.slot = st_r.head_r[hit_fifo*5 +: 5];
			do_store = 1'b1;
			st_nxt.head_r[hit_fifo*5 +: 5] = entry.slot + 5'd1;
		end else if (in_take) begin
			st_nxt.drop_count_r = st_r.drop_count_r + 16'd1;
		end

		// two-entry buffer toward the message store
		unique case ({do_store, out_take})
			2'b10: begin
				st_nxt.buf_r[st_r.buf_count_r[0]] = entry;
				st_nxt.buf_count_r = st_r.buf_count_r + 2'd1;
			end
			2'b01: begin
				st_nxt.buf_r[0] = st_r.buf_r[1];
				st_nxt.buf_count_r = st_r.buf_count_r - 2'd1;
			end
			2'b11: begin
				st_nxt.buf_r[0] = (st_r.buf_count_r == 2'd1) ? entry :
					st_r.buf_r[1];
				st_nxt.buf_r[1] = entry;
			end
			default: ;
		endcase

		// write channel: hold address and data until both are here
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			st_nxt.aw_held_r = 1'b1;
			st_nxt.aw_addr_r = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			st_nxt.w_held_r = 1'b1;
			st_nxt.w_data_r = S_AXI_WDATA;
			st_nxt.w_strb_r = S_AXI_WSTRB;
		end
		unique case (st_r.wr_state_r)
			BUS_IDLE: begin
				if (st_r.aw_held_r && st_r.w_held_r) begin
					waddr = st_r.aw_addr_r;
					st_nxt.aw_held_r = 1'b0;
					st_nxt.w_held_r = 1'b0;
					st_nxt.wr_state_r = BUS_RESP;
					st_nxt.bresp_r = 2'b00;
					for (int b = 0; b < 4; b++)
						wbits[b*8 +: 8] = {8{st_r.w_strb_r[b]}};
					if (waddr == FILTER_CONTROL_GROUP2_ADDR) begin
						for (int f = 0; f < NUM_FILTERS; f++) begin
							// locked while the filter is enabled
							if (!st_r.filter_control_group2_r[f*8 + FILTER_ENABLE_POS])
								mbits[f*8 +: 8] = wbits[f*8 +: 8];
						end
						st_nxt.filter_control_group2_r =
							(st_r.filter_control_group2_r & ~mbits) |
							(st_r.w_data_r & mbits);
					end else if (waddr == FIFO_DIRECTION_ADDR) begin
						mbits = wbits & 32'h0000_ffff;
						st_nxt.fifo_transmit_direction_r =
							16'((32'(st_r.fifo_transmit_direction_r) & ~mbits) |
							(st_r.w_data_r & mbits));
					end else if (waddr == RX_DROP_COUNT_ADDR) begin
						st_nxt.drop_count_r = 16'h0000;
					end else begin
						st_nxt.bresp_r = 2'b10;
					end
				end
			end
			BUS_RESP: begin
				if (S_AXI_BREADY)
					st_nxt.wr_state_r = BUS_IDLE;
			end
			default: st_nxt.wr_state_r = BUS_IDLE;
		endcase

		// read channel
		unique case (st_r.rd_state_r)
			BUS_IDLE: begin
				if (S_AXI_ARVALID) begin
					raddr = S_AXI_ARADDR;
					n = raddr[5:2];
					st_nxt.rd_state_r = BUS_RESP;
					st_nxt.rresp_r = 2'b00;
					st_nxt.rdata_r = 32'h0;
					// transmit reads the head, receive the tail
					ptr = st_r.fifo_transmit_direction_r[n] ?
						st_r.head_r[n*5 +: 5] : st_r.tail_r[n*5 +: 5];
					if (raddr == FILTER_CONTROL_GROUP2_ADDR)
						st_nxt.rdata_r = st_r.filter_control_group2_r;
					else if (raddr == FIFO_DIRECTION_ADDR)
						st_nxt.rdata_r = {16'h0, st_r.fifo_transmit_direction_r};
					else if (raddr == RX_DROP_COUNT_ADDR)
						st_nxt.rdata_r = {16'h0, st_r.drop_count_r};
					else if (raddr[7:6] == FIFO_USER_ADDRESS_BASE[7:6] &&
						raddr[1:0] == 2'b00)
						st_nxt.rdata_r = (FIFO_AREA_BASE +
							32'(n) * 32'(SLOTS_PER_FIFO) * MESSAGE_BYTES +
							32'(ptr) * MESSAGE_BYTES) & 32'hffff_fffc;
					else if (raddr[7:6] == FIFO_MESSAGE_INDEX_BASE[7:6] &&
						raddr[1:0] == 2'b00)
						// transmit: next to send, receive: next slot to fill
						st_nxt.rdata_r = {27'h0, st_r.fifo_transmit_direction_r[n] ?
							st_r.tail_r[n*5 +: 5] : st_r.head_r[n*5 +: 5]};
					else
						st_nxt.rresp_r = 2'b10;
				end
			end
			BUS_RESP: begin
				if (S_AXI_RREADY)
					st_nxt.rd_state_r = BUS_IDLE;
			end
			default: st_nxt.rd_state_r = BUS_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			st_r <= '0;
			st_r.filter_control_group2_r <= FILTER_CONTROL_RESET;
			st_r.fifo_transmit_direction_r <= FIFO_DIRECTION_RESET;
			st_r.head_r <= {NUM_FIFOS{MESSAGE_INDEX_RESET}};
			st_r.tail_r <= {NUM_FIFOS{MESSAGE_INDEX_RESET}};
			st_r.wr_state_r <= BUS_IDLE;
			st_r.rd_state_r <= BUS_IDLE;
		end else if (CLK_EN) begin
			st_r <= st_nxt;
		end
	end

	// bus outputs
	assign S_AXI_AWREADY = CLK_EN && !st_r.aw_held_r;
	assign S_AXI_WREADY = CLK_EN && !st_r.w_held_r;
	assign S_AXI_BVALID = (st_r.wr_state_r == BUS_RESP);
	assign S_AXI_BRESP = st_r.bresp_r;
	assign S_AXI_ARREADY = CLK_EN && (st_r.rd_state_r == BUS_IDLE);
	assign S_AXI_RVALID = (st_r.rd_state_r == BUS_RESP);
	assign S_AXI_RDATA = st_r.rdata_r;
	assign S_AXI_RRESP = st_r.rresp_r;

endmodule // can_filter_fifo_pointers
`default_nettype wire

// [sim/store_sink.sv]
/*
 * store sink standing at the far side of the store stream.
 * assumes CLK and the synchronous active-high reset of the block.
 */
`timescale 1ns/10ps
`default_nettype none
module store_sink
	import can_filter_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic stall,
	input wire store_word_t store_data,
	input wire logic store_valid,
	output logic store_ready,
	output store_word_t last_word,
	output logic [7:0] word_count
);
	// stalls while asked to, so the buffer must hold its words
	assign store_ready = !stall;

	// keeps the latest accepted word and a count of them
	always_ff @(posedge clk) begin
		if (rst) begin
			word_count <= 8'h00;
			last_word <= '0;
		end else if (store_valid && store_ready) begin
			word_count <= word_count + 8'h01;
			last_word <= store_data;
		end
	end
endmodule // store_sink
`default_nettype wire

// [sim/can_filter_fifo_pointers_asserts.sv]
/*
 * concurrent checks on the top ports of the filter block.
 * assumes binding to can_filter_fifo_pointers, one clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
module can_filter_fifo_pointers_asserts
	import can_filter_pkg::*;
(
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic CLK_EN,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic RX_VALID,
	input wire logic RX_READY,
	input wire store_word_t STORE_DATA,
	input wire logic STORE_VALID,
	input wire logic STORE_READY
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	logic [7:0] ar_addr_r;
	logic take_r;

	// remembers the read address and whether an id was taken
	always_ff @(posedge CLK) begin
		if (S_AXI_ARVALID && S_AXI_ARREADY)
			ar_addr_r <= S_AXI_ARADDR;
		take_r <= RX_VALID && RX_READY;
	end

	AST_RD_LAT: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	AST_RD_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY
		|=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data moved");
	AST_AR_BLOCK: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("read taken while answer pending");
	AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY
		|=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write answer moved");
	AST_IDX_HI: assert property (
		S_AXI_RVALID && ar_addr_r[7:6] == 2'b10 |-> S_AXI_RDATA[31:5] == 27'h0)
		else $error("index upper bits set");
	AST_UA_LO: assert property (
		S_AXI_RVALID && ar_addr_r[7:6] == 2'b01 |-> S_AXI_RDATA[1:0] == 2'b00)
		else $error("user address unaligned");
	AST_ST_HOLD: assert property (STORE_VALID && !STORE_READY
		|=> STORE_VALID && $stable(STORE_DATA)) else $error("store word moved");
	AST_ST_CAUSE: assert property ($rose(STORE_VALID) |-> take_r)
		else $error("store without received id");
	AST_RX_FULL: assert property (CLK_EN && !RX_READY |-> STORE_VALID)
		else $error("refused with empty buffer");
endmodule // can_filter_fifo_pointers_asserts

bind can_filter_fifo_pointers can_filter_fifo_pointers_asserts chk (
	.CLK(CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
	.S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
	.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
	.S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_BREADY(S_AXI_BREADY), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
	.STORE_DATA(STORE_DATA), .STORE_VALID(STORE_VALID),
	.STORE_READY(STORE_READY));
`default_nettype wire

// [sim/can_filter_fifo_pointers_bench.sv]
/*
 * self-checking bench: register access over axi4-lite and id traffic.
 * assumes the default fifo area base and the store_sink partner.
 */
`timescale 1ns/10ps
`default_nettype none
module can_filter_fifo_pointers_bench;
	import can_filter_pkg::*;
	logic clk, rst, stall, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, rx_valid, rx_ready;
	logic st_valid, st_ready;
	logic [7:0] awaddr, araddr, word_count;
	logic [31:0] wdata, rdata, v;
	logic [3:0] wstrb;
	logic [15:0] tx_done, rx_taken;
	logic [1:0] bresp, rresp, r;
	rx_ident_t rx_ident;
	store_word_t st_data, last_word;
	int err_count, check_count;

	can_filter_fifo_pointers DUT (.CLK(clk), .SYS_RST(rst), .CLK_EN(1'b1),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.MASK_VALUES(116'h1fffffff), .RX_IDENT(rx_ident), .RX_VALID(rx_valid),
		.RX_READY(rx_ready), .STORE_DATA(st_data), .STORE_VALID(st_valid),
		.STORE_READY(st_ready), .TX_DONE(tx_done), .RX_TAKEN(rx_taken));
	store_sink sink (.clk(clk), .rst(rst), .stall(stall), .store_data(st_data),
		.store_valid(st_valid), .store_ready(st_ready),
		.last_word(last_word), .word_count(word_count));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic stop_test;
		if (err_count == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [37:0] got, input logic [37:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// bounds every wait
	task automatic guard(inout int n);
		n++;
		if (n > 200) begin
			err_count++;
			$display("CHECK FAILED %0t timeout", $time);
			stop_test();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] rs);
		logic ha, hw, hb;
		int n;
		n = 0;
		hb = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!hb) begin
			@(negedge clk);
			ha = awvalid && awready;
			hw = wvalid && wready;
			hb = bvalid;
			rs = bresp;
			@(posedge clk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			guard(n);
		end
		bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic ha, h;
		int n;
		n = 0;
		h = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!h) begin
			@(negedge clk);
			ha = arvalid && arready;
			h = rvalid;
			v = rdata;
			r = rresp;
			@(posedge clk);
			if (ha) arvalid <= 1'b0;
			guard(n);
		end
		rready <= 1'b0;
		chk(v, ed);
		chk(r, er);
		@(posedge clk);
	endtask

	// offers one id, then shows its inverse once released
	task automatic send(input logic [28:0] id);
		logic h;
		int n;
		n = 0;
		h = 1'b0;
		rx_ident <= id;
		rx_valid <= 1'b1;
		while (!h) begin
			@(negedge clk);
			h = rx_ready;
			@(posedge clk);
			guard(n);
		end
		rx_valid <= 1'b0;
		rx_ident <= ~id;
		@(posedge clk);
	endtask

	task automatic wait_count(input logic [7:0] c);
		int n;
		n = 0;
		while (word_count !== c) begin
			@(posedge clk);
			guard(n);
		end
	endtask

	// main sequence
	initial begin
		{rst, stall, awvalid, wvalid, bready, arvalid, rready} = 7'h41;
		{awaddr, araddr, wdata, wstrb, rx_valid} = '0;
		rx_ident = '0;
		tx_done = 16'h0000;
		rx_taken = 16'h0000;
		err_count = 0;
		check_count = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		stall <= 1'b0;
		@(posedge clk);
		rd(8'h00, 32'h0, 2'b00);
		rd(8'h8c, 32'h0, 2'b00);
		wr(8'h00, 32'h1f00_2583, r);
		rd(8'h00, 32'h1f00_2583, 2'b00);
		send(29'h123);
		repeat (4) @(posedge clk);
		chk(word_count, 38'h0);
		send(29'h8);
		wait_count(8'h01);
		chk(last_word, {29'h8, 4'h3, 5'h00});
		wr(8'h00, 32'h0000_a500, r);
		rd(8'h00, 32'h0000_a583, 2'b00);
		send(29'h123);
		wait_count(8'h02);
		chk(last_word, {29'h123, 4'h5, 5'h00});
		rd(8'h8c, 32'h1, 2'b00);
		rd(8'h4c, 32'h1600, 2'b00);
		wr(8'h04, 32'h8, r);
		rd(8'h4c, 32'h1610, 2'b00);
		rd(8'h8c, 32'h0, 2'b00);
		// one sent message on fifo 3, one consumed on receive fifo 5
		tx_done <= 16'h0008;
		rx_taken <= 16'h0020;
		@(posedge clk);
		tx_done <= 16'h0000;
		rx_taken <= 16'h0000;
		rd(8'h8c, 32'h1, 2'b00);
		rd(8'h4c, 32'h1610, 2'b00);
		rd(8'h54, 32'h1a10, 2'b00);
		wr(8'hfc, 32'h1, r);
		chk(r, 38'h2);
		rd(8'hfc, 32'h0, 2'b10);
		// stalled sink: two words queue, then the input is no longer ready
		stall <= 1'b1;
		send(29'h8);
		send(29'h8);
		@(negedge clk);
		chk(rx_ready, 38'h0);
		@(posedge clk);
		stall <= 1'b0;
		wait_count(8'h04);
		chk(last_word, {29'h8, 4'h3, 5'h02});
		stop_test();
	end
endmodule // can_filter_fifo_pointers_bench
`default_nettype wire
